// file: design/bus_ctrl_pkg.sv
package bus_ctrl_pkg;

   // ----------------------------------------
   // Machine cycle kinds, sequencer and arbiter states
   // ----------------------------------------
   typedef enum logic [2:0] {
      KIND_OPFETCH,
      KIND_MEM_RD,
      KIND_MEM_WR,
      KIND_IO_RD,
      KIND_IO_WR,
      KIND_INT_ACK
   } cycle_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_T1,
      ST_T2,
      ST_TW,
      ST_T3,
      ST_HALT,
      ST_HOLD
   } seq_state_t;

   typedef enum logic [1:0] {
      AR_RUN,
      AR_ACK,
      AR_OFF,
      AR_BACK
   } arb_state_t;

   // ----------------------------------------
   // Status codes {io_m, s1, s0}
   // ----------------------------------------
   localparam logic [2:0] STAT_MEM_WR  = 3'h1;
   localparam logic [2:0] STAT_MEM_RD  = 3'h2;
   localparam logic [2:0] STAT_OPFETCH = 3'h3;
   localparam logic [2:0] STAT_IO_WR   = 3'h5;
   localparam logic [2:0] STAT_IO_RD   = 3'h6;
   localparam logic [2:0] STAT_INT_ACK = 3'h7;
   localparam logic [2:0] STAT_HALT    = 3'h0;
   localparam logic [2:0] STAT_FLOAT   = 3'h0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic       STROBE_RST   = 1'h1;
   localparam logic       OE_RST       = 1'h0;
   localparam logic [7:0] BYTE_RST     = 8'h00;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS  = 10000;
   localparam int RESUME_PS      = 5000;
   localparam int RESUME_CYC_INT =
      (RESUME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESUME_CYC_MIN =
      (RESUME_CYC_INT < 1) ? 1 : RESUME_CYC_INT;
   localparam logic [3:0] RESUME_CYC = 4'(RESUME_CYC_MIN);

endpackage

// file: design/hold_if.sv
`timescale 1ns/10ps
`default_nettype none

interface hold_if;
   logic req;
   logic bus_free;
   logic grant;
   logic released;

   modport arb (
      input  req,
      input  bus_free,
      output grant,
      output released
   );

   modport seq (
      output req,
      output bus_free,
      input  grant,
      input  released
   );
endinterface

`default_nettype wire

// file: design/hold_arbiter.sv
`timescale 1ns/10ps
`default_nettype none

module hold_arbiter
   import bus_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Hold handshake
   hold_if.arb       hif
);

   arb_state_t  st_r;
   logic        grant_r;
   logic        released_r;
   logic [3:0]  back_cnt_r;

   assign hif.grant    = grant_r;
   assign hif.released = released_r;

   // ----------------------------------------
   // Request, grant and release sequence
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= AR_RUN;
         grant_r    <= 1'b0;
         released_r <= 1'b0;
         back_cnt_r <= 4'h0;
      end else begin
         case (st_r)
            AR_RUN: begin
               if (hif.req && hif.bus_free) begin
                  st_r    <= AR_ACK;
                  grant_r <= 1'b1;
               end
            end
            AR_ACK: begin
               st_r       <= AR_OFF;
               released_r <= 1'b1;
            end
            AR_OFF: begin
               if (!hif.req) begin
                  st_r       <= AR_BACK;
                  grant_r    <= 1'b0;
                  back_cnt_r <= 4'h1;
               end
            end
            AR_BACK: begin
               if (back_cnt_r >= RESUME_CYC) begin
                  st_r       <= AR_RUN;
                  released_r <= 1'b0;
               end else begin
                  back_cnt_r <= back_cnt_r + 4'h1;
               end
            end
            default: begin
               st_r <= AR_RUN;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// file: design/cpu_bus_control_and_hold.sv
// Function
// - Interrupt acknowledge status is one one one
// - Halt floats io/mem, status low; hold too
// - Status bit one valid early in cycle
// - Status valid at start, stable whole cycle
// - Read strobe low commands data onto bus
// - Read/write strobes float in hold, halt, reset
// - Write strobe low; data valid at rise
// - Ready low inserts whole wait states
// - Finish current transfer before giving bus
// - Internal work continues while bus surrendered
// - No driving until request removed
// - Granted: float address, data, read/write strobes, io/mem
// - Grant means bus released next cycle
// - Grant falls after request withdrawn
// - Drive again half cycle after grant falls; here two cycles after
// - Low address in first state, data after
// - Latch strobe in first state, never floated
// - Upper address driven, floated hold/halt/reset
// - Reset clears grant, enable and counter
`timescale 1ns/10ps
`default_nettype none

module cpu_bus_control_and_hold
   import bus_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic                      CLK,
   input  wire logic                      RESETN,
   // Core side requests
   input  wire logic                      REQ_VALID,
   input  wire bus_ctrl_pkg::cycle_kind_t REQ_KIND,
   input  wire logic [15:0]               REQ_ADDR,
   input  wire logic [7:0]                REQ_WDATA,
   input  wire logic                      HALT_REQ,
   output logic                           REQ_DONE,
   output logic [7:0]                     REQ_RDATA,
   output logic                           BUS_SURRENDERED,
   // Multiplexed address and data bus
   input  wire logic [7:0]                MUXED_ADDR_DATA_IN,
   output logic [7:0]                     MUXED_ADDR_DATA_OUT,
   output logic                           MUXED_ADDR_DATA_OE,
   // Upper address
   output logic [7:0]                     UPPER_ADDRESS,
   output logic                           UPPER_ADDRESS_OE,
   // Control strobes
   output logic                           ADDRESS_LATCH_STROBE,
   output logic                           READ_STROBE_N,
   output logic                           READ_STROBE_N_OE,
   output logic                           WRITE_STROBE_N,
   output logic                           WRITE_STROBE_N_OE,
   output logic                           INT_ACK_STROBE_N,
   // Machine cycle status
   output logic                           IO_MEMORY_SELECT,
   output logic                           IO_MEMORY_SELECT_OE,
   output logic                           CYCLE_STATUS_1,
   output logic                           CYCLE_STATUS_0,
   // Ready and bus hold
   input  wire logic                      READY_IN,
   input  wire logic                      BUS_REQUEST_IN,
   output logic                           BUS_GRANT_OUT
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [2:0] status_of(input cycle_kind_t k);
      logic [2:0] s;
      s = STAT_OPFETCH;
      case (k)
         KIND_MEM_RD:  s = STAT_MEM_RD;
         KIND_MEM_WR:  s = STAT_MEM_WR;
         KIND_IO_RD:   s = STAT_IO_RD;
         KIND_IO_WR:   s = STAT_IO_WR;
         KIND_INT_ACK: s = STAT_INT_ACK;
         default:      s = STAT_OPFETCH;
      endcase
      return s;
   endfunction

   function automatic logic is_write(input cycle_kind_t k);
      return (k == KIND_MEM_WR) || (k == KIND_IO_WR);
   endfunction

   function automatic logic is_io(input cycle_kind_t k);
      return (k == KIND_IO_RD) || (k == KIND_IO_WR);
   endfunction

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // ----------------------------------------
   // Hold arbiter
   // ----------------------------------------
   hold_if hif ();

   hold_arbiter u_arb (
      .clk   (CLK),
      .rst_n (rst_n),
      .hif   (hif)
   );

   seq_state_t  st_r;
   seq_state_t  st_nxt;
   cycle_kind_t kind_r;
   logic [15:0] addr_r;
   logic [7:0]  wdata_r;
   logic        start;
   cycle_kind_t cur_kind;
   logic [15:0] cur_addr;
   logic [7:0]  cur_wdata;

   assign hif.req      = BUS_REQUEST_IN;
   assign hif.bus_free = (st_r == ST_IDLE) || (st_r == ST_HALT) ||
                         (st_r == ST_T3);
   assign BUS_GRANT_OUT = hif.grant;

   assign start = (st_r == ST_IDLE) && REQ_VALID && !REQ_DONE &&
                  !hif.req && !hif.grant && !hif.released;
   assign cur_kind  = start ? REQ_KIND  : kind_r;
   assign cur_addr  = start ? REQ_ADDR  : addr_r;
   assign cur_wdata = start ? REQ_WDATA : wdata_r;

   // ----------------------------------------
   // Machine cycle sequencer
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (hif.grant) begin
               st_nxt = ST_HOLD;
            end else if (start) begin
               st_nxt = ST_T1;
            end else if (HALT_REQ && !hif.req && !hif.grant) begin
               st_nxt = ST_HALT;
            end
         end
         ST_T1: begin
            st_nxt = ST_T2;
         end
         ST_T2, ST_TW: begin
            if (READY_IN) begin
               st_nxt = ST_T3;
            end else begin
               st_nxt = ST_TW;
            end
         end
         ST_T3: begin
            st_nxt = ST_IDLE;
         end
         ST_HALT: begin
            if (hif.grant) begin
               st_nxt = ST_HOLD;
            end else if (!HALT_REQ) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (!hif.released) begin
               st_nxt = HALT_REQ ? ST_HALT : ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Request capture
   // ----------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         kind_r  <= KIND_OPFETCH;
         addr_r  <= 16'h0000;
         wdata_r <= BYTE_RST;
      end else if (start) begin
         kind_r  <= REQ_KIND;
         addr_r  <= REQ_ADDR;
         wdata_r <= REQ_WDATA;
      end
   end

   // ----------------------------------------
   // Completion and read data
   // ----------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         REQ_DONE        <= 1'b0;
         REQ_RDATA       <= BYTE_RST;
         BUS_SURRENDERED <= 1'b0;
      end else begin
         REQ_DONE <= (st_r == ST_T3);
         if ((st_r == ST_T3) && !is_write(kind_r)) begin
            REQ_RDATA <= MUXED_ADDR_DATA_IN;
         end
         BUS_SURRENDERED <= (st_nxt == ST_HOLD);
      end
   end

   // ----------------------------------------
   // Status and address pins
   // ----------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         IO_MEMORY_SELECT     <= 1'b0;
         IO_MEMORY_SELECT_OE  <= OE_RST;
         CYCLE_STATUS_1       <= 1'b0;
         CYCLE_STATUS_0       <= 1'b0;
         UPPER_ADDRESS        <= BYTE_RST;
         UPPER_ADDRESS_OE     <= OE_RST;
         ADDRESS_LATCH_STROBE <= 1'b0;
      end else begin
         ADDRESS_LATCH_STROBE <= (st_nxt == ST_T1);
         case (st_nxt)
            ST_T1: begin
               {IO_MEMORY_SELECT, CYCLE_STATUS_1, CYCLE_STATUS_0} <=
                  status_of(cur_kind);
               IO_MEMORY_SELECT_OE <= 1'b1;
               UPPER_ADDRESS       <= is_io(cur_kind) ? cur_addr[7:0] :
                                      cur_addr[15:8];
               UPPER_ADDRESS_OE    <= 1'b1;
            end
            ST_HALT: begin
               {IO_MEMORY_SELECT, CYCLE_STATUS_1, CYCLE_STATUS_0} <=
                  STAT_HALT;
               IO_MEMORY_SELECT_OE <= 1'b0;
               UPPER_ADDRESS_OE    <= 1'b0;
            end
            ST_HOLD: begin
               {IO_MEMORY_SELECT, CYCLE_STATUS_1, CYCLE_STATUS_0} <=
                  STAT_FLOAT;
               IO_MEMORY_SELECT_OE <= 1'b0;
               UPPER_ADDRESS_OE    <= 1'b0;
            end
            default: begin
               IO_MEMORY_SELECT_OE <= 1'b1;
               UPPER_ADDRESS_OE    <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Data bus and strobes
   // ----------------------------------------
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         MUXED_ADDR_DATA_OUT <= BYTE_RST;
         MUXED_ADDR_DATA_OE  <= OE_RST;
         READ_STROBE_N       <= STROBE_RST;
         READ_STROBE_N_OE    <= OE_RST;
         WRITE_STROBE_N      <= STROBE_RST;
         WRITE_STROBE_N_OE   <= OE_RST;
         INT_ACK_STROBE_N    <= STROBE_RST;
      end else begin
         READ_STROBE_N    <= STROBE_RST;
         WRITE_STROBE_N   <= STROBE_RST;
         INT_ACK_STROBE_N <= STROBE_RST;
         case (st_nxt)
            ST_T1: begin
               MUXED_ADDR_DATA_OUT <= cur_addr[7:0];
               MUXED_ADDR_DATA_OE  <= 1'b1;
               READ_STROBE_N_OE    <= 1'b1;
               WRITE_STROBE_N_OE   <= 1'b1;
            end
            ST_T2, ST_TW, ST_T3: begin
               if (is_write(cur_kind)) begin
                  MUXED_ADDR_DATA_OUT <= cur_wdata;
                  MUXED_ADDR_DATA_OE  <= 1'b1;
                  WRITE_STROBE_N      <= 1'b0;
               end else begin
                  MUXED_ADDR_DATA_OE <= 1'b0;
                  if (cur_kind == KIND_INT_ACK) begin
                     INT_ACK_STROBE_N <= 1'b0;
                  end else begin
                     READ_STROBE_N <= 1'b0;
                  end
               end
               READ_STROBE_N_OE  <= 1'b1;
               WRITE_STROBE_N_OE <= 1'b1;
            end
            ST_HALT, ST_HOLD: begin
               MUXED_ADDR_DATA_OE <= 1'b0;
               READ_STROBE_N_OE   <= 1'b0;
               WRITE_STROBE_N_OE  <= 1'b0;
            end
            default: begin
               MUXED_ADDR_DATA_OE <= 1'b0;
               READ_STROBE_N_OE   <= 1'b1;
               WRITE_STROBE_N_OE  <= 1'b1;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// file: tb/bus_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module bus_mem_model (
   // Clock
   input  wire logic       clk,
   // Device bus
   input  wire logic       ale,
   input  wire logic [7:0] ad_out,
   input  wire logic       ad_oe,
   input  wire logic [7:0] upper,
   input  wire logic       rd_n,
   input  wire logic       rd_oe,
   input  wire logic       wr_n,
   input  wire logic       wr_oe,
   input  wire logic       inta_n,
   input  wire logic [2:0] stat,
   output logic [7:0]      ad_in,
   output logic            ready,
   // Test control and capture
   input  wire logic [3:0] wait_cnt,
   output logic [7:0]      lat_lo,
   output logic [7:0]      lat_hi,
   output logic [2:0]      lat_stat,
   output logic [7:0]      wr_byte
);
   logic [3:0] cnt_r  = 4'h0;
   logic [7:0] last_r = 8'h00;
   logic       rd_act;
   logic       wr_act;

   assign rd_act = (!rd_n && rd_oe) || !inta_n;
   assign wr_act = !wr_n && wr_oe;
   // Released bus with no read or acknowledge strobe shows the inverse of its last level
   assign ad_in  = ad_oe ? ad_out :
                   (rd_act ? (lat_lo ^ lat_hi ^ 8'h5A) : ~last_r);
   assign ready  = (cnt_r >= wait_cnt);

   always @(posedge clk) begin
      last_r <= ad_in;
      if (ale) begin
         cnt_r    <= 4'h0;
         lat_lo   <= ad_in;
         lat_hi   <= upper;
         lat_stat <= stat;
      end else if (rd_act || wr_act) begin
         cnt_r <= cnt_r + 4'h1;
      end
      if (wr_act) begin
         wr_byte <= ad_in;
      end
   end
endmodule

`default_nettype wire

// file: tb/cpu_bus_control_and_hold_sva.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_bus_control_and_hold_sva
   import bus_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RESETN,
   // Bus side
   input  wire logic       READY_IN,
   input  wire logic       BUS_REQUEST_IN,
   input  wire logic       BUS_SURRENDERED,
   input  wire logic [7:0] MUXED_ADDR_DATA_OUT,
   input  wire logic       MUXED_ADDR_DATA_OE,
   input  wire logic       UPPER_ADDRESS_OE,
   input  wire logic       ADDRESS_LATCH_STROBE,
   input  wire logic       READ_STROBE_N,
   input  wire logic       READ_STROBE_N_OE,
   input  wire logic       WRITE_STROBE_N,
   input  wire logic       WRITE_STROBE_N_OE,
   input  wire logic       INT_ACK_STROBE_N,
   input  wire logic       IO_MEMORY_SELECT,
   input  wire logic       IO_MEMORY_SELECT_OE,
   input  wire logic       CYCLE_STATUS_1,
   input  wire logic       CYCLE_STATUS_0,
   input  wire logic       BUS_GRANT_OUT
);
   logic [2:0] stat;
   logic       rd_on;
   logic       floated;

   assign stat    = {IO_MEMORY_SELECT, CYCLE_STATUS_1, CYCLE_STATUS_0};
   assign rd_on   = !READ_STROBE_N && READ_STROBE_N_OE;
   assign floated = !MUXED_ADDR_DATA_OE && !IO_MEMORY_SELECT_OE &&
                    !READ_STROBE_N_OE && !WRITE_STROBE_N_OE &&
                    !UPPER_ADDRESS_OE;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_intack_status_ones: assert property (
      !INT_ACK_STROBE_N |-> stat == STAT_INT_ACK)
      else $error("status not all ones during acknowledge");
   a_float_status_low: assert property (
      !IO_MEMORY_SELECT_OE |-> !CYCLE_STATUS_1 && !CYCLE_STATUS_0)
      else $error("status bits not low while floated");
   a_status_held: assert property (
      $rose(ADDRESS_LATCH_STROBE) |=> $stable(stat) [*2])
      else $error("status changed inside machine cycle");
   a_latch_first_state: assert property (
      ADDRESS_LATCH_STROBE |-> MUXED_ADDR_DATA_OE ##1 !ADDRESS_LATCH_STROBE)
      else $error("latch strobe not a one state address pulse");
   a_strobes_float_together: assert property (
      !IO_MEMORY_SELECT_OE |-> floated)
      else $error("strobe or address driven while floated");
   a_read_bus_free: assert property (
      rd_on |-> !MUXED_ADDR_DATA_OE)
      else $error("data bus driven during read strobe");
   a_write_data_held: assert property (
      (!WRITE_STROBE_N && WRITE_STROBE_N_OE) ##1 !WRITE_STROBE_N
      |-> MUXED_ADDR_DATA_OE && $stable(MUXED_ADDR_DATA_OUT))
      else $error("write data not held under write strobe");
   a_wait_extends_read: assert property (
      $fell(READ_STROBE_N) && READ_STROBE_N_OE && !READY_IN
      |=> !READ_STROBE_N [*2])
      else $error("read ended without wait state");
   a_grant_after_xfer: assert property (
      $rose(BUS_GRANT_OUT) |-> READ_STROBE_N && WRITE_STROBE_N &&
      INT_ACK_STROBE_N && !ADDRESS_LATCH_STROBE)
      else $error("grant during bus transfer");
   a_grant_then_float: assert property (
      $rose(BUS_GRANT_OUT) |=> floated && BUS_SURRENDERED)
      else $error("bus not released cycle after grant");
   a_hold_kept_off: assert property (
      BUS_SURRENDERED && BUS_REQUEST_IN |=> !IO_MEMORY_SELECT_OE)
      else $error("bus driven while request present");
   a_grant_drops: assert property (
      BUS_GRANT_OUT && !BUS_REQUEST_IN |-> ##[1:2] !BUS_GRANT_OUT)
      else $error("grant held after request removed");
   a_resume_time: assert property (
      $fell(BUS_GRANT_OUT) |-> !IO_MEMORY_SELECT_OE ##1
      !IO_MEMORY_SELECT_OE ##1 IO_MEMORY_SELECT_OE)
      else $error("bus resumed at wrong time");

   c_wait_read: cover property ($fell(READ_STROBE_N) && !READY_IN);
   c_grant: cover property ($rose(BUS_GRANT_OUT));
   c_intack: cover property (!INT_ACK_STROBE_N);
   c_halt: cover property (!IO_MEMORY_SELECT_OE && !BUS_SURRENDERED);
endmodule

bind cpu_bus_control_and_hold cpu_bus_control_and_hold_sva u_sva (
   .CLK, .RESETN, .READY_IN, .BUS_REQUEST_IN, .BUS_SURRENDERED,
   .MUXED_ADDR_DATA_OUT, .MUXED_ADDR_DATA_OE, .UPPER_ADDRESS_OE,
   .ADDRESS_LATCH_STROBE, .READ_STROBE_N, .READ_STROBE_N_OE,
   .WRITE_STROBE_N, .WRITE_STROBE_N_OE, .INT_ACK_STROBE_N,
   .IO_MEMORY_SELECT, .IO_MEMORY_SELECT_OE, .CYCLE_STATUS_1,
   .CYCLE_STATUS_0, .BUS_GRANT_OUT
);

`default_nettype wire

// file: tb/cpu_bus_control_and_hold_test.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_bus_control_and_hold_test;
   import bus_ctrl_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        CLK            = 1'b0;
   logic        RESETN         = 1'b0;
   logic        REQ_VALID      = 1'b0;
   cycle_kind_t REQ_KIND       = KIND_OPFETCH;
   logic [15:0] REQ_ADDR       = 16'h0000;
   logic [7:0]  REQ_WDATA      = 8'h00;
   logic        HALT_REQ       = 1'b0;
   logic        BUS_REQUEST_IN = 1'b0;
   logic [3:0]  wait_cnt       = 4'h0;
   logic [7:0]  REQ_RDATA, MUXED_ADDR_DATA_IN, MUXED_ADDR_DATA_OUT;
   logic [7:0]  UPPER_ADDRESS, lat_lo, lat_hi, wr_byte;
   logic [2:0]  lat_stat;
   logic        REQ_DONE, BUS_SURRENDERED, MUXED_ADDR_DATA_OE;
   logic        UPPER_ADDRESS_OE, ADDRESS_LATCH_STROBE, READ_STROBE_N;
   logic        READ_STROBE_N_OE, WRITE_STROBE_N, WRITE_STROBE_N_OE;
   logic        INT_ACK_STROBE_N, IO_MEMORY_SELECT, IO_MEMORY_SELECT_OE;
   logic        CYCLE_STATUS_1, CYCLE_STATUS_0, READY_IN, BUS_GRANT_OUT;
   int          error_cnt  = 0;
   int          n_compared = 0;
   int          cyc        = 0;

   always #5 CLK = ~CLK;

   cpu_bus_control_and_hold u_dut (
      .CLK, .RESETN, .REQ_VALID, .REQ_KIND, .REQ_ADDR, .REQ_WDATA,
      .HALT_REQ, .REQ_DONE, .REQ_RDATA, .BUS_SURRENDERED,
      .MUXED_ADDR_DATA_IN, .MUXED_ADDR_DATA_OUT, .MUXED_ADDR_DATA_OE,
      .UPPER_ADDRESS, .UPPER_ADDRESS_OE, .ADDRESS_LATCH_STROBE,
      .READ_STROBE_N, .READ_STROBE_N_OE, .WRITE_STROBE_N,
      .WRITE_STROBE_N_OE, .INT_ACK_STROBE_N, .IO_MEMORY_SELECT,
      .IO_MEMORY_SELECT_OE, .CYCLE_STATUS_1, .CYCLE_STATUS_0,
      .READY_IN, .BUS_REQUEST_IN, .BUS_GRANT_OUT
   );

   bus_mem_model u_mem (
      .clk(CLK), .ale(ADDRESS_LATCH_STROBE),
      .ad_out(MUXED_ADDR_DATA_OUT), .ad_oe(MUXED_ADDR_DATA_OE),
      .upper(UPPER_ADDRESS), .rd_n(READ_STROBE_N),
      .rd_oe(READ_STROBE_N_OE), .wr_n(WRITE_STROBE_N),
      .wr_oe(WRITE_STROBE_N_OE), .inta_n(INT_ACK_STROBE_N),
      .stat({IO_MEMORY_SELECT, CYCLE_STATUS_1, CYCLE_STATUS_0}),
      .ad_in(MUXED_ADDR_DATA_IN), .ready(READY_IN), .wait_cnt,
      .lat_lo, .lat_hi, .lat_stat, .wr_byte
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input bit ok, input string msg);
      n_compared++;
      if (!ok) begin
         error_cnt++;
         $display("unexpected at %0t ns: %s", $time, msg);
      end
   endtask

   task automatic chk_float(input string msg);
      chk({IO_MEMORY_SELECT_OE, READ_STROBE_N_OE, WRITE_STROBE_N_OE,
         UPPER_ADDRESS_OE, MUXED_ADDR_DATA_OE} === 5'h00, msg);
   endtask

   task automatic cnt_to(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 20) begin
         @(posedge CLK);
         #1;
         n++;
      end
   endtask

   function automatic logic [2:0] stat_of(input cycle_kind_t k);
      case (k)
         KIND_MEM_RD:  return STAT_MEM_RD;
         KIND_MEM_WR:  return STAT_MEM_WR;
         KIND_IO_RD:   return STAT_IO_RD;
         KIND_IO_WR:   return STAT_IO_WR;
         KIND_INT_ACK: return STAT_INT_ACK;
         default:      return STAT_OPFETCH;
      endcase
   endfunction

   task automatic start_req(input cycle_kind_t k, input logic [15:0] a,
                            input logic [7:0] d);
      @(posedge CLK);
      REQ_KIND  <= k;
      REQ_ADDR  <= a;
      REQ_WDATA <= d;
      REQ_VALID <= 1'b1;
   endtask

   task automatic wait_done(output int n);
      n = 0;
      do begin
         @(posedge CLK);
         #1;
         n++;
      end while (REQ_DONE !== 1'b1 && n < 100);
      chk(REQ_DONE === 1'b1, "no completion");
      @(posedge CLK);
      REQ_VALID <= 1'b0;
      #1;
   endtask

   task automatic do_cycle(input cycle_kind_t k, input logic [15:0] a,
                           input logic [7:0] d, input int w);
      logic       wr;
      logic [7:0] hi;
      int         n;
      wr = (k == KIND_MEM_WR) || (k == KIND_IO_WR);
      hi = (k == KIND_IO_RD || k == KIND_IO_WR) ? a[7:0] : a[15:8];
      wait_cnt = 4'(w);
      start_req(k, a, d);
      wait_done(n);
      chk(n == 4 + w, "cycle length");
      chk(lat_stat === stat_of(k), "status code");
      chk(lat_lo === a[7:0] && lat_hi === hi, "address");
      if (wr)
         chk(wr_byte === d, "write data");
      else
         chk(REQ_RDATA === (a[7:0] ^ hi ^ 8'h5A), "read data");
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_all_kinds();
      for (int i = 0; i < 6; i++) begin
         do_cycle(cycle_kind_t'(i), 16'hC3A0 + 16'(i), 8'h3C + 8'(i),
                  0);
      end
      $display("t_all_kinds done");
   endtask

   task automatic t_waits();
      do_cycle(KIND_MEM_RD, 16'h12FF, 8'h00, 2);
      do_cycle(KIND_IO_WR, 16'h0081, 8'hFF, 1);
      do_cycle(KIND_OPFETCH, 16'h8001, 8'h00, 3);
      $display("t_waits done");
   endtask

   task automatic t_halt();
      @(posedge CLK);
      HALT_REQ <= 1'b1;
      repeat (3) @(posedge CLK);
      #1;
      chk_float("halt float");
      chk({CYCLE_STATUS_1, CYCLE_STATUS_0} === 2'h0, "halt status");
      @(posedge CLK);
      HALT_REQ <= 1'b0;
      repeat (3) @(posedge CLK);
      do_cycle(KIND_MEM_RD, 16'hFF00, 8'h00, 0);
      $display("t_halt done");
   endtask

   task automatic t_hold();
      int n;
      bit ok;
      wait_cnt = 4'h3;
      start_req(KIND_MEM_RD, 16'h4455, 8'h00);
      @(posedge CLK);
      BUS_REQUEST_IN <= 1'b1;
      wait_done(n);
      chk(n == 6, "transfer cut by hold");
      chk(REQ_RDATA === 8'h4B, "read under hold");
      cnt_to(BUS_GRANT_OUT, 1'b1, n);
      chk(BUS_GRANT_OUT === 1'b1, "no grant");
      @(posedge CLK);
      #1;
      chk_float("hold float");
      chk(BUS_SURRENDERED === 1'b1, "not surrendered");
      start_req(KIND_MEM_WR, 16'h7788, 8'h99);
      ok = 1'b1;
      repeat (6) begin
         @(posedge CLK);
         #1;
         ok &= ADDRESS_LATCH_STROBE === 1'b0 && IO_MEMORY_SELECT_OE === 1'b0;
      end
      chk(ok, "bus taken in hold");
      @(posedge CLK);
      BUS_REQUEST_IN <= 1'b0;
      #1;
      cnt_to(BUS_GRANT_OUT, 1'b0, n);
      chk(n >= 1 && n <= 2, "grant held");
      cnt_to(IO_MEMORY_SELECT_OE, 1'b1, n);
      chk(n == 2, "resume time");
      wait_done(n);
      chk(wr_byte === 8'h99, "write after hold");
      $display("t_hold done");
   endtask

   task automatic t_reset_grant();
      int n;
      @(posedge CLK);
      BUS_REQUEST_IN <= 1'b1;
      #1;
      cnt_to(BUS_GRANT_OUT, 1'b1, n);
      @(posedge CLK);
      RESETN <= 1'b0;
      #1;
      chk(BUS_GRANT_OUT === 1'b0, "grant kept in reset");
      chk_float("reset float");
      repeat (3) @(posedge CLK);
      BUS_REQUEST_IN <= 1'b0;
      RESETN         <= 1'b1;
      repeat (4) @(posedge CLK);
      #1;
      chk(IO_MEMORY_SELECT_OE === 1'b1, "no restart");
      $display("t_reset_grant done");
   endtask

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         $display("unexpected at %0t ns: timeout", $time);
         report_and_stop();
      end
   end

   initial begin
      repeat (16) @(posedge CLK);
      #1;
      chk_float("reset float");
      chk(BUS_GRANT_OUT === 1'b0, "reset grant");
      @(posedge CLK);
      RESETN <= 1'b1;
      repeat (3) @(posedge CLK);
      t_all_kinds();
      t_waits();
      t_halt();
      t_hold();
      t_reset_grant();
      report_and_stop();
   end
endmodule

`default_nettype wire
